/* common/stp_regs.svh */
`ifndef STP_REGS_SVH
`define STP_REGS_SVH

// Register offsets on the plain register port
`define STP_ADDR_GEN_CTRL 8'h23
`define STP_ADDR_SEL_A 8'h24
`define STP_ADDR_SEL_B 8'h25
`define STP_ADDR_STATUS 8'h26

// General timer control field positions
`define STP_GEN_SYNC_HOLD_BIT 7
`define STP_GEN_ASYNC_RST_BIT 1
`define STP_GEN_SYNC_RST_BIT 0
`define STP_GEN_CTRL_RESET 8'h00
`define STP_SEL_RESET 3'h0

// Shared divider geometry: width of the low field that must be all ones per tap
`define STP_DIV_WIDTH 10
`define STP_TAP8_BITS 3
`define STP_TAP64_BITS 6
`define STP_TAP256_BITS 8
`define STP_TAP1024_BITS 10

// Core clock period in ns
`define STP_CLK_PERIOD_NS 40

`endif

/* common/stp_pkg.sv */
package stp_pkg;

  // Count source selection codes for one timer
  typedef enum logic [2:0] {
    STP_SRC_OFF     = 3'b000,
    STP_SRC_DIRECT  = 3'b001,
    STP_SRC_DIV8    = 3'b010,
    STP_SRC_DIV64   = 3'b011,
    STP_SRC_DIV256  = 3'b100,
    STP_SRC_DIV1024 = 3'b101,
    STP_SRC_FALL    = 3'b110,
    STP_SRC_RISE    = 3'b111
  } stp_src_t;

endpackage

/* common/stp_pin_if.sv */
`timescale 1ns/100ps
// Synchronized pin level and edge pulses from one count pin
interface stp_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* logic/stp_ext_sync.sv */
`timescale 1ns/100ps
module stp_ext_sync
  import stp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Raw count pin
  input wire logic i_pin,
  // Synchronized result
  stp_pin_if.src o_edge
);

  logic pin_lat;
  logic samp_q;
  logic prev_q;
  logic rise_q;
  logic fall_q;

  // Latch open in the high clock phase; pad is sampled even when driven as output
  always_latch begin
    if (i_core_clk) begin
      pin_lat <= i_pin;
    end
  end

  // Sampling register after the latch
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      samp_q <= pin_lat;
      prev_q <= samp_q;
    end
  end

  // Registered edge pulses give the total 2.5 to 3.5 cycle pin-to-count delay
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= samp_q & ~prev_q;
      fall_q <= ~samp_q & prev_q;
    end
  end

  // A pin faster than half the clock rate aliases; no filter is attempted
  assign o_edge.level = samp_q;
  assign o_edge.rise = rise_q;
  assign o_edge.fall = fall_q;

  chk_edge_latency: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (samp_q && !prev_q) |=> rise_q ##1 !rise_q)
    else $error("rise pulse not one cycle after sampled edge");

  chk_edge_exclusive: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(rise_q && fall_q))
    else $error("rise and fall pulses together");

endmodule

/* logic/stp_prescaler.sv */
`timescale 1ns/100ps
`include "stp_regs.svh"
// Functional notes
// - Select code one ticks the timer on every core clock cycle.
// - Divider gives taps at clock divided by 8, 64, 256 and 1024.
// - Each timer picks its own tap from the one shared divider.
// - Divider runs freely regardless of any timer selection.
// - First divided tick comes 1 to N cycles after enabling.
// - Divider reset restarts the shared divider, shifting phase for both timers.
// - Each count pin is sampled every cycle, then edge detected.
// - Sampling uses a high-phase transparent latch then rising-edge registers.
// - Code seven ticks on rising pin edges, code six on falling edges.
// - Pin edge reaches the counter 2.5 to 3.5 cycles later.
// - Pin ticks go straight to the timer, never through the divider.
// - Sync divider reset bit self-clears next cycle unless hold mode is set.
// - In hold mode both divider reset bits stay as written.
// - Writing hold mode zero clears both divider reset bits.
// - Select code zero delivers no ticks; the timer stays stopped.
// - Pin transitions count even while the pin is driven as output.
module stp_prescaler
  import stp_pkg::*;
#(
  parameter int DIV_WIDTH = `STP_DIV_WIDTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // External count pins
  input wire logic i_ext_count_pin_a,
  input wire logic i_ext_count_pin_b,
  // Timer ticks
  output logic o_timer_a_tick,
  output logic o_timer_b_tick,
  // Divider reset levels for the timers and the separate async divider
  output logic o_sync_divider_reset,
  output logic o_async_divider_reset
);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  logic sync_hold_mode_q;
  logic sync_divider_reset_q;
  logic async_divider_reset_q;
  logic [DIV_WIDTH-1:0] div_cnt_q;
  stp_src_t sel_q [2];
  logic [7:0] rdata_q;
  logic [3:0] tap;
  logic [1:0] pins;
  logic [1:0] ticks;
  logic [1:0] levels;
  logic gen_wr;

  // Whole control reset word; only the hold mode bit takes its field at reset, the reset bits load zero
  localparam logic [7:0] GEN_CTRL_RESET = `STP_GEN_CTRL_RESET;

  assign gen_wr = i_wr && (i_addr == `STP_ADDR_GEN_CTRL);
  assign pins = {i_ext_count_pin_b, i_ext_count_pin_a};

  // General control: hold mode keeps reset bits, otherwise they self-clear
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_hold_mode_q <= GEN_CTRL_RESET[`STP_GEN_SYNC_HOLD_BIT];
      sync_divider_reset_q <= 1'b0;
      async_divider_reset_q <= 1'b0;
    end else if (gen_wr) begin
      // Bits six to two are not stored
      sync_hold_mode_q <= i_wdata[`STP_GEN_SYNC_HOLD_BIT];
      sync_divider_reset_q <= i_wdata[`STP_GEN_SYNC_RST_BIT];
      async_divider_reset_q <= i_wdata[`STP_GEN_ASYNC_RST_BIT];
    end else if (!sync_hold_mode_q) begin
      // A plain reset request lasts one cycle; dropping hold releases both
      sync_divider_reset_q <= 1'b0;
      async_divider_reset_q <= 1'b0;
    end
  end

  // Per-timer count source selection
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q[0] <= STP_SRC_OFF;
      sel_q[1] <= STP_SRC_OFF;
    end else if (i_wr && (i_addr == `STP_ADDR_SEL_A)) begin
      sel_q[0] <= stp_src_t'(i_wdata[2:0]);
    end else if (i_wr && (i_addr == `STP_ADDR_SEL_B)) begin
      sel_q[1] <= stp_src_t'(i_wdata[2:0]);
    end
  end

  // Shared divider; it ignores the selections, only the reset bit restarts it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_q <= '0;
    end else if (sync_divider_reset_q) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Carry points of the counter; held reset keeps every tap quiet
  assign tap[0] = (&div_cnt_q[`STP_TAP8_BITS-1:0]) && !sync_divider_reset_q;
  assign tap[1] = (&div_cnt_q[`STP_TAP64_BITS-1:0]) && !sync_divider_reset_q;
  assign tap[2] = (&div_cnt_q[`STP_TAP256_BITS-1:0]) && !sync_divider_reset_q;
  assign tap[3] = (&div_cnt_q[`STP_TAP1024_BITS-1:0]) && !sync_divider_reset_q;

  // One synchronizer and one tick selector per timer
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    stp_pin_if u_pin ();

    stp_ext_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rstn (i_rstn),
      .i_pin (pins[g]),
      .o_edge (u_pin.src)
    );

    assign levels[g] = u_pin.level;

    // Tick selection; taps are phase-free of enabling, so first tick lands 1 to N later
    always_comb begin
      unique case (sel_q[g])
        STP_SRC_OFF: ticks[g] = 1'b0;
        STP_SRC_DIRECT: ticks[g] = 1'b1;
        STP_SRC_DIV8: ticks[g] = tap[0];
        STP_SRC_DIV64: ticks[g] = tap[1];
        STP_SRC_DIV256: ticks[g] = tap[2];
        STP_SRC_DIV1024: ticks[g] = tap[3];
        STP_SRC_FALL: ticks[g] = u_pin.fall;
        STP_SRC_RISE: ticks[g] = u_pin.rise;
      endcase
    end

    chk_stopped_quiet: assert property (
      (sel_q[g] == STP_SRC_OFF) |-> !ticks[g])
      else $error("tick while source is off");

    chk_direct_every: assert property (
      (sel_q[g] == STP_SRC_DIRECT) [*3] |-> ticks[g])
      else $error("direct source missed a cycle");

    chk_pin_edge_tick: assert property (
      (sel_q[g] == STP_SRC_RISE) |-> (ticks[g] == u_pin.rise))
      else $error("rising source does not follow pin edge");

    chk_fall_edge_tick: assert property (
      (sel_q[g] == STP_SRC_FALL) |-> (ticks[g] == u_pin.fall))
      else $error("falling source does not follow pin edge");
  end

  assign o_timer_a_tick = ticks[0];
  assign o_timer_b_tick = ticks[1];
  assign o_sync_divider_reset = sync_divider_reset_q;
  assign o_async_divider_reset = async_divider_reset_q;

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `STP_ADDR_GEN_CTRL: rdata_q <= {sync_hold_mode_q, 5'h00, async_divider_reset_q,
                                        sync_divider_reset_q};
        `STP_ADDR_SEL_A: rdata_q <= {5'h00, sel_q[0]};
        `STP_ADDR_SEL_B: rdata_q <= {5'h00, sel_q[1]};
        `STP_ADDR_STATUS: rdata_q <= {6'h00, levels};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

  // Tap period sequence: a tap followed by eight free-running cycles
  sequence s_tap8_free;
    tap[0] ##1 (!sync_divider_reset_q) [*8];
  endsequence

  chk_tap8_period: assert property (
    s_tap8_free |-> tap[0])
    else $error("divide-by-8 tap not eight cycles apart");

  chk_tap8_single: assert property (
    tap[0] |=> !tap[0])
    else $error("divider tap longer than one cycle");

  chk_free_running: assert property (
    !sync_divider_reset_q |=> (div_cnt_q == DIV_WIDTH'($past(div_cnt_q) + 1'b1)))
    else $error("divider did not advance");

  chk_reset_restart: assert property (
    sync_divider_reset_q |=> (div_cnt_q == '0))
    else $error("divider not restarted by reset bit");

  chk_auto_clear: assert property (
    (!sync_hold_mode_q && !gen_wr) |=> !sync_divider_reset_q && !async_divider_reset_q)
    else $error("reset bit not cleared without hold mode");

  chk_hold_keep: assert property (
    (sync_hold_mode_q && !gen_wr) |=> $stable(sync_divider_reset_q) && $stable(async_divider_reset_q))
    else $error("reset bits changed during hold mode");

  chk_hold_release: assert property (
    (gen_wr && !i_wdata[7] && (i_wdata[1:0] == 2'b00)) |=> !sync_divider_reset_q && !async_divider_reset_q)
    else $error("hold release did not clear reset bits");

  // Wider taps must also be single-cycle pulses
  chk_tap64_single: assert property (
    tap[1] |=> !tap[1])
    else $error("divide-by-64 tap longer than one cycle");

  // Read data stand one cycle only, zero without a read the cycle before
  chk_rdata_idle: assert property (
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data not zero without a read");

  // A plain reset request held in hold mode keeps the taps silent
  chk_held_quiet: assert property (
    sync_divider_reset_q |-> (tap == 4'h0))
    else $error("tap pulse while divider reset is held");

  chk_reserved_zero: assert property (
    (i_rd && (i_addr == `STP_ADDR_GEN_CTRL)) |=> (o_rdata[6:2] == 5'h00))
    else $error("reserved control bits read nonzero");

endmodule

/* tb/stp_pin_src.sv */
`timescale 1ns/100ps
// Far-side count source: toggles its pin with a half period given in core cycles
module stp_pin_src (
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic [3:0] i_half,
  // Driven pin
  output logic o_pin
);
  logic [3:0] cnt_q;
  initial begin
    o_pin = 1'b0;
    cnt_q = 4'h0;
  end
  // Half period of two or more cycles keeps the sampler safe; when stopped the pin holds still
  always @(negedge i_core_clk) begin
    if (i_run) begin
      if (cnt_q + 4'h1 >= i_half) begin
        cnt_q <= 4'h0;
        o_pin <= ~o_pin;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

/* tb/shared_timer_prescaler_tb.sv */
`timescale 1ns/100ps
module shared_timer_prescaler_tb;
  logic clk, rstn, wr, rd, tk_a, tk_b, sdr, adr, pa, pb, run_a, run_b;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] half_a, half_b;
  logic m_sync, m_async, m_hold, m_ph;
  logic [2:0] sel_a, sel_b;
  int m_cnt, mismatches, n_checks, ra, fa, rb, fb, ta, tb;
  // Design and the two pin sources
  stp_prescaler dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_ext_count_pin_a(pa), .i_ext_count_pin_b(pb), .o_timer_a_tick(tk_a),
    .o_timer_b_tick(tk_b), .o_sync_divider_reset(sdr), .o_async_divider_reset(adr));
  stp_pin_src src_a (.i_core_clk(clk), .i_run(run_a), .i_half(half_a), .o_pin(pa));
  stp_pin_src src_b (.i_core_clk(clk), .i_run(run_b), .i_half(half_b), .o_pin(pb));
  // Core clock, 40 ns
  always #20 clk = ~clk;
  // Reference divider and control bits, moved on the same edges as the design
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {m_sync, m_async, m_hold, m_ph, sel_a, sel_b} <= '0;
      m_cnt <= 0;
    end else begin
      m_cnt <= m_sync ? 0 : (m_cnt + 1) % 1024;
      if (m_sync) m_ph <= 1'b1;
      if (wr && addr == 8'h23) {m_hold, m_async, m_sync} <= {wdata[7], wdata[1:0]};
      else if (!m_hold) {m_async, m_sync} <= 2'b00;
      if (wr && addr == 8'h24) sel_a <= wdata[2:0];
      if (wr && addr == 8'h25) sel_b <= wdata[2:0];
    end
  end
  function automatic logic exp_tick(logic [2:0] s);
    case (s)
      3'h1: return 1'b1;
      3'h2: return !m_sync && m_cnt % 8 == 7;
      3'h3: return !m_sync && m_cnt % 64 == 63;
      3'h4: return !m_sync && m_cnt % 256 == 255;
      3'h5: return !m_sync && m_cnt == 1023;
      default: return 1'b0;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Both reset levels are compared mid-cycle; ticks once the divider phase is known
  always @(negedge clk) begin
    if (rstn) begin
      check({7'h0, sdr}, {7'h0, m_sync});
      check({7'h0, adr}, {7'h0, m_async});
      if (m_ph && sel_a < 3'h6) check({7'h0, tk_a}, {7'h0, exp_tick(sel_a)});
      if (m_ph && sel_b < 3'h6) check({7'h0, tk_b}, {7'h0, exp_tick(sel_b)});
    end
  end
  // Tally of pin edges and of ticks
  always @(posedge pa) ra++;
  always @(negedge pa) fa++;
  always @(posedge pb) rb++;
  always @(negedge pb) fb++;
  always @(negedge clk) begin
    if (tk_a === 1'b1) ta++;
    if (tk_b === 1'b1) tb++;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    {clk, wr, rd, run_a, run_b, rstn} = '0;
    {addr, wdata} = '0;
    half_a = 4'h2;
    half_b = 4'h3;
    void'($urandom(32'h7ec5));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, status and an unmapped place
    for (int i = 0; i < 4; i++) rd_chk(8'(8'h23 + i), 8'h00);
    rd_chk(8'h40, 8'h00);
    // Hold keeps both reset bits; reserved bits read zero
    wr_reg(8'h23, {1'b1, 5'($urandom), 2'b11});
    repeat (5) @(posedge clk);
    rd_chk(8'h23, 8'h83);
    check({7'h0, adr}, 8'h01);
    wr_reg(8'h23, 8'h00);
    rd_chk(8'h23, 8'h00);
    $display("test control done");
    // Every divided and plain source, one mid-run divider restart
    for (int i = 0; i < 10; i++) begin
      wr_reg(8'h24, 8'(i < 6 ? i : $urandom % 6));
      wr_reg(8'h25, 8'($urandom % 6));
      if (i == 7) wr_reg(8'h23, 8'h01);
      repeat (1100) @(posedge clk);
    end
    $display("test taps done");
    // Reset in mid-run drops hold
    wr_reg(8'h23, 8'h81);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h23, 8'h00);
    $display("test rerun done");
    // Edge modes, switched in while the pins stand still
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h24, 8'(7 - k));
      wr_reg(8'h25, 8'(6 + k));
      repeat (4) @(posedge clk);
      ra = 0;
      fa = 0;
      rb = 0;
      fb = 0;
      ta = 0;
      tb = 0;
      half_a <= 4'(2 + $urandom % 4);
      half_b <= 4'(2 + $urandom % 4);
      run_a <= 1'b1;
      run_b <= 1'b1;
      repeat (200) @(posedge clk);
      run_a <= 1'b0;
      run_b <= 1'b0;
      repeat (6) @(posedge clk);
      check(8'(ta), 8'(k ? fa : ra));
      check(8'(tb), 8'(k ? rb : fb));
      rd_chk(8'h26, {6'h0, pb, pa});
    end
    $display("test pins done");
    end_sim();
  end
endmodule
